/* File: design/watchdog_consts.svh */
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

`define WDG_CTRL_OFFSET      12'h0d8
`define WDG_CTRL_RESET       8'hfe
`define WDG_ACT_BIT          0
`define WDG_TRIG_BIT         1
`define WDG_CLK_MHZ          250
`define WDG_STEP_CYCLES      12'hc00
`define WDG_RST_PULSE_NS     500
`define WDG_RST_PULSE_CYCLES ((`WDG_RST_PULSE_NS * `WDG_CLK_MHZ) / 1000)

`endif

/* File: design/watchdog_pkg.sv */
// Types shared by the watchdog design
`default_nettype none
package watchdog_pkg;
    // Avalon-MM slave request from the bus fabric
    typedef struct packed {
        logic [9:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } avmm_req_t;

    // Avalon-MM slave answer
    typedef struct packed {
        logic [7:0] readdata;
        logic       waitrequest;
    } avmm_rsp_t;

    // Low-power request from the CPU core
    typedef struct packed {
        logic wait_req;
        logic stop_req;
    } power_req_t;

    // Watchdog state machine
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_FROZEN = 2'b01,
        ST_RESET  = 2'b10
    } wdg_state_t;
endpackage
`default_nettype wire

/* File: design/watchdog_reset_timer.sv */
// Watchdog reset timer with Avalon-MM register access
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "watchdog_consts.svh"
`default_nettype none
module watchdog_reset_timer (
    // Clock and reset
    input  wire logic                    core_clk_in,
    input  wire logic                    rst_n_in,
    // Register bus
    input  wire watchdog_pkg::avmm_req_t bus_req_in,
    output var  watchdog_pkg::avmm_rsp_t bus_rsp_out,
    // Option straps and pins
    input  wire logic                    hw_option_select_in,
    input  wire logic                    pin_gated_halt_option_in,
    input  wire logic                    nmi_pin_in,
    // CPU power requests
    input  wire watchdog_pkg::power_req_t power_req_in,
    input  wire logic                    stop_exit_in,
    output logic                         enter_stop_out,
    output logic                         enter_wait_out,
    // Chip reset pin, open drain
    output logic                         reset_pin_out,
    output logic                         reset_pin_oe_n_out
);
    import watchdog_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] nmi_sync_q;
    logic [1:0] nmi_sync_d;
    logic       nmi_pin_high;

    // Two stages before anything reads the pin
    always_comb begin
        nmi_sync_d = {nmi_sync_q[0], nmi_pin_in};
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            nmi_sync_q <= 2'h0;
        end else begin
            nmi_sync_q <= nmi_sync_d;
        end
    end

    assign nmi_pin_high = nmi_sync_q[1];

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Register bits 7..2 map to counter bits 0..5 in reverse
    function automatic logic [5:0] reverse6(input logic [5:0] v);
        logic [5:0] r;
        r = 6'h0;
        for (int i = 0; i < 6; i++) begin
            r[i] = v[5 - i];
        end
        return r;
    endfunction

    function automatic logic ctrl_hit(input avmm_req_t rq);
        return rq.address == 10'(`WDG_CTRL_OFFSET);
    endfunction

    // ==========================================================
    // Watchdog state
    // ==========================================================
    localparam logic [11:0] STEP_LAST  = 12'(`WDG_STEP_CYCLES - 1);
    localparam int          PULSE_INT  = `WDG_RST_PULSE_CYCLES < 1 ? 1 : `WDG_RST_PULSE_CYCLES;
    localparam logic [7:0]  PULSE_LAST = 8'(PULSE_INT - 1);

    wdg_state_t  state_q, state_d;
    logic [6:0]  count_q, count_d;      // {trigger, T5..T0}
    logic        active_q, active_d;
    logic [11:0] step_q, step_d;
    logic [7:0]  pulse_q, pulse_d;
    logic        hw_opt_q, hw_opt_d;
    logic        strap_done_q, strap_done_d;
    logic        wr_hit;
    logic        step_tick;
    logic        stop_freezes;
    logic        active_now;

    // A write lands only at the edge where waitrequest is low, never twice
    assign wr_hit     = bus_req_in.write && !bus_rsp_out.waitrequest && ctrl_hit(bus_req_in);
    assign active_now = active_q || hw_opt_q;
    assign step_tick  = (step_q == STEP_LAST);
    // Only the pin-gated option with the pin high truly stops the counter
    assign stop_freezes = active_now && pin_gated_halt_option_in && nmi_pin_high;

    // Next-state logic for counter, activation and reset pulse
    always_comb begin
        state_d      = state_q;
        count_d      = count_q;
        active_d     = active_q;
        step_d       = step_q;
        pulse_d      = pulse_q;
        hw_opt_d     = hw_opt_q;
        strap_done_d = 1'b1;
        // Strap is caught on the first clock after reset release
        if (!strap_done_q) begin
            hw_opt_d = hw_option_select_in;
        end
        unique case (state_q)
            ST_RUN: begin
                // Wait requests leave the count running untouched
                if (wr_hit) begin
                    // A write reloads the count and restarts the interval
                    count_d = {bus_req_in.writedata[`WDG_TRIG_BIT],
                               reverse6(bus_req_in.writedata[7:2])};
                    step_d  = 12'h000;
                    // Activation is one-way until chip reset
                    active_d = active_q | bus_req_in.writedata[`WDG_ACT_BIT];
                end else if (power_req_in.stop_req && stop_freezes) begin
                    state_d = ST_FROZEN;
                end else begin
                    // Counter runs whether or not active
                    step_d = step_tick ? 12'h000 : 12'(step_q + 12'h001);
                    if (step_tick) begin
                        count_d = 7'(count_q - 7'h01);
                    end
                end
                // Trigger bit low while active launches reset
                if ((active_now || active_d) && !count_d[6]) begin
                    state_d = ST_RESET;
                    pulse_d = 8'h00;
                end
            end
            ST_FROZEN: begin
                // Held count resumes on leaving stop
                if (stop_exit_in) begin
                    state_d = ST_RUN;
                end
            end
            ST_RESET: begin
                pulse_d = 8'(pulse_q + 8'h01);
                // The pulse ends on its own after PULSE_INT cycles, counted in pulse_q up to PULSE_LAST
                if (pulse_q == PULSE_LAST) begin
                    state_d = ST_RUN;
                    pulse_d = 8'h00;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Register the watchdog state
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q      <= ST_RUN;
            count_q      <= 7'h7f;
            active_q     <= 1'b0;
            step_q       <= 12'h000;
            pulse_q      <= 8'h00;
            hw_opt_q     <= 1'b0;
            strap_done_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            count_q      <= count_d;
            active_q     <= active_d;
            step_q       <= step_d;
            pulse_q      <= pulse_d;
            hw_opt_q     <= hw_opt_d;
            strap_done_q <= strap_done_d;
        end
    end

    // ==========================================================
    // Register bus slave
    // ==========================================================
    logic [7:0] rdata_q, rdata_d;
    logic       ack_q, ack_d;
    logic [7:0] reg_view;

    // Reset value 1111 1110 comes from count 7F and activation low
    assign reg_view = {reverse6(count_q[5:0]), count_q[6], active_now};

    // One wait state on every access; unmapped reads return zero
    always_comb begin
        ack_d   = (bus_req_in.read || bus_req_in.write) && !ack_q;
        rdata_d = rdata_q;
        if (bus_req_in.read && !ack_q) begin
            rdata_d = ctrl_hit(bus_req_in) ? reg_view : 8'h00;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // One driver for the whole answer struct
    assign bus_rsp_out = '{readdata: rdata_q,
                           waitrequest: (bus_req_in.read || bus_req_in.write) && !ack_q};

    // ==========================================================
    // Outputs
    // ==========================================================
    logic stop_q, stop_d, wait_q, wait_d;

    // Stop becomes wait when an active watchdog must keep running
    always_comb begin
        stop_d = power_req_in.stop_req && (!active_now || stop_freezes);
        wait_d = power_req_in.wait_req ||
                 (power_req_in.stop_req && active_now && !stop_freezes);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            stop_q <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
            wait_q <= wait_d;
        end
    end

    assign enter_stop_out     = stop_q;
    assign enter_wait_out     = wait_q;
    assign reset_pin_out      = 1'b0;
    assign reset_pin_oe_n_out = (state_q != ST_RESET);

    // ==========================================================
    // Checks
    // ==========================================================
    property p_step_period;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_q == ST_RUN && step_tick && !wr_hit && !power_req_in.stop_req) |=>
            count_q == 7'($past(count_q) - 7'h01);
    endproperty
    a_step_period: assert property (p_step_period) else $error("count missed its step");

    sequence s_expire;
        state_q == ST_RUN && active_now && !count_d[6];
    endsequence
    property p_reset_pulse;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        s_expire |=> !reset_pin_oe_n_out [*8];
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too short");

    property p_hw_forced;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        strap_done_q |=> $stable(hw_opt_q) && (!hw_opt_q || reg_view[0]);
    endproperty
    a_hw_forced: assert property (p_hw_forced) else $error("activation not forced");

    property p_sticky;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        active_q |=> active_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("activation dropped");

    property p_soft_reset;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_q == ST_RUN && wr_hit && bus_req_in.writedata[0] && !bus_req_in.writedata[1])
            |=> state_q == ST_RESET;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("no software reset");

    property p_reload;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_q == ST_RUN && wr_hit) |=>
            reg_view[7:1] == $past(bus_req_in.writedata[7:1]) && step_q == 12'h000;
    endproperty
    a_reload: assert property (p_reload) else $error("write did not reload");

    property p_stop_as_wait;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (power_req_in.stop_req && active_now && !pin_gated_halt_option_in) |=>
            enter_wait_out && !enter_stop_out;
    endproperty
    a_stop_as_wait: assert property (p_stop_as_wait) else $error("stop not turned into wait");

    property p_frozen_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_q == ST_FROZEN && !stop_exit_in) |=> $stable(count_q);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold) else $error("frozen count moved");
endmodule
`default_nettype wire

/* File: dv/watchdog_reset_timer_tb.sv */
// Self-checking testbench for the watchdog reset timer
`default_nettype none
module watchdog_reset_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import watchdog_pkg::*;

    // =========================================
    // Signals and design instance
    logic       clk;
    logic       rst_n;
    logic       hw_opt;
    logic       pin_opt;
    logic       nmi;
    logic       stop_exit;
    avmm_req_t  req;
    avmm_rsp_t  rsp;
    power_req_t pwr;
    logic       en_stop;
    logic       en_wait;
    logic       oe_n;
    logic [7:0] rd;
    int         n_fail;
    int         comparisons;

    watchdog_reset_timer i_watchdog_reset_timer (
        .core_clk_in              (clk),
        .rst_n_in                 (rst_n),
        .bus_req_in               (req),
        .bus_rsp_out              (rsp),
        .hw_option_select_in      (hw_opt),
        .pin_gated_halt_option_in (pin_opt),
        .nmi_pin_in               (nmi),
        .power_req_in             (pwr),
        .stop_exit_in             (stop_exit),
        .enter_stop_out           (en_stop),
        .enter_wait_out           (en_wait),
        .reset_pin_out            (),
        .reset_pin_oe_n_out       (oe_n)
    );

    // =========================================
    // Clock, verdict and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The whole run needs about 40k cycles, so 80k means a hang
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    // =========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Request is held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] d, input logic [9:0] a = 10'h0d8);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{address: a, read: !wr, write: wr, writedata: d};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        chk(8'(n < 50), 8'h01);
        // Read data taken at the accepting edge, then the request drops
        rd = rsp.readdata;
        req <= '0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk);
        rst_n <= 1'b0;
        hw_opt <= strap;
        pwr <= '0;
        stop_exit <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
    endtask

    // Power request stays held after the check; caller releases it
    task automatic pw(input logic w, input logic s, input logic [1:0] exp);
        @(posedge clk);
        pwr <= '{wait_req: w, stop_req: s};
        repeat (3) @(negedge clk);
        chk({6'h0, en_stop, en_wait}, {6'h0, exp});
    endtask

    // Cycles until the reset pin is pulled, bounded
    task automatic wait_pull(output int n);
        n = 0;
        while (oe_n !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // =========================================
    // Scenarios
    task automatic t_timer();
        do_reset(1'b0);
        bus(1'b0, 8'h00);
        chk(rd, 8'hfe);
        bus(1'b0, 8'h00, 10'h0d3);
        chk(rd, 8'h00);
        bus(1'b1, 8'h42);
        cyc(100);
        bus(1'b0, 8'h00);
        chk(rd, 8'h42);
        cyc(3100);
        bus(1'b0, 8'h00);
        chk(rd, 8'h82);
        // Timer reads are taken twice and must agree
        bus(1'b0, 8'h00);
        chk(rd, 8'h82);
        // Count zero with trigger set: next step clears the trigger bit
        bus(1'b1, 8'h02);
        bus(1'b1, 8'h00, 10'h0d3);
        cyc(3200);
        bus(1'b0, 8'h00);
        chk(rd, 8'hfc);
        chk({7'h0, oe_n}, 8'h01);
    endtask

    task automatic t_expire();
        int n;
        do_reset(1'b0);
        bus(1'b1, 8'h03);
        bus(1'b1, 8'h02);
        bus(1'b0, 8'h00);
        chk(rd, 8'h03);
        wait_pull(n);
        chk(8'(n > 2900 && n < 3200), 8'h01);
        n = 0;
        while (oe_n === 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n), 8'd125);
    endtask

    task automatic t_soft();
        int n;
        do_reset(1'b0);
        bus(1'b1, 8'h03);
        // Start-up code: an active watchdog is cleared by a forced reset
        bus(1'b0, 8'h00);
        chk(rd, 8'h03);
        if (rd[0]) begin
            bus(1'b1, 8'hfd);
        end
        wait_pull(n);
        chk(8'(n < 6), 8'h01);
    endtask

    task automatic t_always_on();
        do_reset(1'b1);
        bus(1'b0, 8'h00);
        chk(rd, 8'hff);
        bus(1'b1, 8'h42);
        pw(1'b0, 1'b1, 2'b01);
        cyc(3100);
        bus(1'b0, 8'h00);
        chk(rd, 8'h83);
        // Count one with trigger set expires after two steps unless refreshed
        repeat (3) begin
            bus(1'b1, 8'h83);
            cyc(5000);
            chk({7'h0, oe_n}, 8'h01);
        end
    endtask

    task automatic t_power();
        do_reset(1'b0);
        pw(1'b0, 1'b1, 2'b10);
        pw(1'b1, 1'b0, 2'b01);
        bus(1'b1, 8'h42);
        cyc(3100);
        bus(1'b0, 8'h00);
        chk(rd, 8'h82);
    endtask

    task automatic t_freeze();
        do_reset(1'b1);
        pin_opt <= 1'b1;
        bus(1'b1, 8'h42);
        pw(1'b0, 1'b1, 2'b01);
        @(posedge clk);
        pwr <= '0;
        nmi <= 1'b1;
        cyc(4);
        pw(1'b0, 1'b1, 2'b10);
        cyc(3300);
        stop_exit <= 1'b1;
        pwr <= '0;
        @(posedge clk);
        stop_exit <= 1'b0;
        bus(1'b0, 8'h00);
        chk(rd, 8'h43);
        cyc(3100);
        bus(1'b0, 8'h00);
        chk(rd, 8'h83);
    endtask

    // =========================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        hw_opt = 1'b0;
        pin_opt = 1'b0;
        nmi = 1'b0;
        stop_exit = 1'b0;
        req = '0;
        pwr = '0;
        n_fail = 0;
        comparisons = 0;
        t_timer();
        t_expire();
        t_soft();
        t_always_on();
        t_power();
        t_freeze();
        print_verdict();
    end
endmodule
`default_nettype wire
